// ---- verilog/rsts_steer.sv ----
`timescale 1ns/1ps
`include "rsts_regs.svh"

module rsts_steer #(
   parameter int                    NUM_CH   = 4,
   parameter int                    CH_DEPTH = 255,
   parameter logic [CH_DEPTH*8-1:0] CH_WMASK = {CH_DEPTH{8'hFF}}
) (
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   input  wire rsts_pkg::rsts_access_type       acc,
   output logic      [7:0]                      rd_data,
   output logic                                 rd_valid,
   output rsts_pkg::rsts_access_type            shr,
   input  wire logic [7:0]                      shr_rdata,
   output logic      [7:0]                      selector,
   output logic      [NUM_CH*CH_DEPTH*8-1:0]    ch_regs
);

   rsts_pkg::rsts_route_type route;
   logic [7:0]               next_selector;
   logic [7:0]               next_rd_data;
   logic                     next_rd_valid;
   logic [NUM_CH-1:0]        ch_wr;
   logic                     ch_rd;
   logic [7:0]               ch_rdata [NUM_CH];
   logic [7:0]               ch_pick;
   logic                     sel_hit_wr;

   rsts_decode u_decode (
      .selector (selector),
      .addr     (acc.addr),
      .route    (route)
   );

   assign sel_hit_wr = acc.wr
                     && route.target == rsts_pkg::RSTS_TO_SELECTOR;

   // selector register
   always_comb begin
      next_selector = selector;
      if (sel_hit_wr) begin
         // all eight bits stored as written
         next_selector = acc.wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         selector <= `RSTS_SEL_RESET;
      end else begin
         selector <= next_selector;
      end
   end

   // shared set forwarding, gated so aliases never reach both spaces
   always_comb begin
      shr       = acc;
      shr.wr    = acc.wr && route.target == rsts_pkg::RSTS_TO_SHARED;
      shr.rd    = acc.rd && route.target == rsts_pkg::RSTS_TO_SHARED;
   end

   // channel write enables
   always_comb begin
      ch_wr = '0;
      if (acc.wr) begin
         if (route.target == rsts_pkg::RSTS_TO_BCAST) begin
            ch_wr = '1;
         end else if (route.target == rsts_pkg::RSTS_TO_SINGLE) begin
            ch_wr[route.channel] = 1'b1;
         end
      end
   end

   assign ch_rd = acc.rd
               && (route.target == rsts_pkg::RSTS_TO_SINGLE
               ||  route.target == rsts_pkg::RSTS_TO_BCAST);

   // four identical sets, same offsets
   for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      rsts_regset #(
         .DEPTH (CH_DEPTH),
         .WMASK (CH_WMASK)
      ) u_set (
         .clock (clock),
         .rst_n (rst_n),
         .wr    (ch_wr[c]),
         .addr  (acc.addr),
         .wdata (acc.wdata),
         .rdata (ch_rdata[c]),
         .regs  (ch_regs[c*CH_DEPTH*8 +: CH_DEPTH*8])
      );
   end

   // reads ignore the broadcast bit
   assign ch_pick = ch_rdata[route.channel];

   // read data, one cycle after the strobe
   always_comb begin
      next_rd_data  = rd_data;
      next_rd_valid = acc.rd;
      if (acc.rd) begin
         if (route.target == rsts_pkg::RSTS_TO_SELECTOR) begin
            // selector is not readable; constant keeps it deterministic
            next_rd_data = `RSTS_SEL_READ;
         end else if (ch_rd) begin
            next_rd_data = ch_pick;
         end else begin
            next_rd_data = shr_rdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_data  <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end

   // helper state for the checks below
   logic       seen_sel_wr;
   logic       next_seen_sel_wr;
   logic [7:0] chk_pick;

   always_comb begin
      next_seen_sel_wr = seen_sel_wr | sel_hit_wr;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_sel_wr <= 1'b0;
      end else begin
         seen_sel_wr <= next_seen_sel_wr;
      end
   end

   assign chk_pick = ch_rdata[selector[`RSTS_IDX_MSB:`RSTS_IDX_LSB]];

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_sel_write_takes: assert property (
      acc.wr && acc.addr == `RSTS_SEL_ADDR
      |=> selector == $past(acc.wdata))
      else $error("selector did not take write to its address");

   a_sel_holds_value: assert property (
      !(acc.wr && acc.addr == `RSTS_SEL_ADDR) |=> $stable(selector))
      else $error("selector changed without a write");

   a_sel_reset_zero: assert property (
      !seen_sel_wr |-> selector == `RSTS_SEL_RESET)
      else $error("selector not zero before first write");

   a_bcast_all_wr: assert property (
      acc.wr && acc.addr != `RSTS_SEL_ADDR
      && selector[`RSTS_BCAST_BIT] && selector[`RSTS_CHEN_BIT]
      |-> ch_wr == '1 && !shr.wr)
      else $error("broadcast write missed a channel");

   a_single_ch_wr: assert property (
      acc.wr && acc.addr != `RSTS_SEL_ADDR
      && !selector[`RSTS_BCAST_BIT] && selector[`RSTS_CHEN_BIT]
      |-> ch_wr == (NUM_CH)'(1) << selector[`RSTS_IDX_MSB:`RSTS_IDX_LSB])
      else $error("single channel write went to wrong set");

   a_chan_off_gated: assert property (
      !selector[`RSTS_CHEN_BIT] |-> ch_wr == '0 && !ch_rd)
      else $error("channel access with enable clear");

   a_shared_when_off: assert property (
      !selector[`RSTS_CHEN_BIT] && acc.addr != `RSTS_SEL_ADDR
      |-> shr.wr == acc.wr && shr.rd == acc.rd)
      else $error("shared access dropped with enable clear");

   a_alias_to_chan: assert property (
      selector[`RSTS_CHEN_BIT] |-> !shr.wr && !shr.rd)
      else $error("shared set reached while channels enabled");

   a_sel_never_chan: assert property (
      acc.addr == `RSTS_SEL_ADDR |-> ch_wr == '0 && !shr.wr)
      else $error("selector address leaked to a register set");

   a_read_indexed: assert property (
      acc.rd && acc.addr != `RSTS_SEL_ADDR && selector[`RSTS_CHEN_BIT]
      |=> rd_valid && rd_data == $past(chk_pick))
      else $error("channel read not from indexed channel");

   a_read_shared: assert property (
      acc.rd && acc.addr != `RSTS_SEL_ADDR && !selector[`RSTS_CHEN_BIT]
      |=> rd_valid && rd_data == $past(shr_rdata))
      else $error("shared read returned wrong data");

   a_sel_read_const: assert property (
      acc.rd && acc.addr == `RSTS_SEL_ADDR
      |=> rd_valid && rd_data == `RSTS_SEL_READ)
      else $error("selector read returned unexpected value");

   a_bcast_then_off: assert property (
      acc.wr && acc.addr == `RSTS_SEL_ADDR && !acc.wdata[`RSTS_CHEN_BIT]
      ##1 (acc.wr && acc.addr != `RSTS_SEL_ADDR)
      |-> shr.wr && ch_wr == '0)
      else $error("write after leaving channel space not shared");

   a_rd_valid_timing: assert property (
      rd_valid == $past(acc.rd))
      else $error("read answer not one cycle after strobe");

   a_rd_data_holds: assert property (
      !acc.rd |=> $stable(rd_data))
      else $error("read data changed without a read");

   a_wr_gates_chan: assert property (
      !acc.wr |-> ch_wr == '0)
      else $error("channel write without a write strobe");

   a_rd_gates_sets: assert property (
      !acc.rd |-> !ch_rd && !shr.rd)
      else $error("set read without a read strobe");

   a_sel_rd_no_set: assert property (
      acc.addr == `RSTS_SEL_ADDR |-> !ch_rd && !shr.rd)
      else $error("selector read reached a register set");

   a_bcast_rd_one: assert property (
      acc.rd && acc.addr != `RSTS_SEL_ADDR
      && selector[`RSTS_BCAST_BIT] && selector[`RSTS_CHEN_BIT]
      |-> ch_rd && !shr.rd)
      else $error("broadcast read not from one channel");

   a_single_rd_chan: assert property (
      acc.rd && acc.addr != `RSTS_SEL_ADDR
      && !selector[`RSTS_BCAST_BIT] && selector[`RSTS_CHEN_BIT]
      |-> ch_rd && !shr.rd)
      else $error("single channel read not from channel set");

   a_shr_copies: assert property (
      shr.addr == acc.addr && shr.wdata == acc.wdata)
      else $error("shared set sees wrong address or data");

   a_bcast_off_shr: assert property (
      acc.wr && acc.addr != `RSTS_SEL_ADDR
      && selector[`RSTS_BCAST_BIT] && !selector[`RSTS_CHEN_BIT]
      |-> shr.wr && ch_wr == '0)
      else $error("broadcast bit alone reached channel sets");

   a_off_rd_shared: assert property (
      acc.rd && acc.addr != `RSTS_SEL_ADDR && !selector[`RSTS_CHEN_BIT]
      |-> shr.rd && !ch_rd)
      else $error("read with enable clear missed shared set");

   a_wr_shape: assert property (
      $onehot0(ch_wr) || ch_wr == '1)
      else $error("channel write enables neither single nor all");

   a_sel_wr_no_set: assert property (
      sel_hit_wr |-> !ch_rd && !shr.rd && !shr.wr)
      else $error("selector write leaked into a set access");

   a_alias_zero_wr: assert property (
      acc.wr && acc.addr == 8'h00 && selector[`RSTS_CHEN_BIT]
      |-> ch_wr != '0 && !shr.wr)
      else $error("write to shared alias missed channel set");

   a_alias_zero_rd: assert property (
      acc.rd && acc.addr == 8'h00 && selector[`RSTS_CHEN_BIT]
      |-> ch_rd && !shr.rd)
      else $error("read of shared alias missed channel set");

   a_one_space: assert property (
      !(shr.wr && ch_wr != '0) && !(shr.rd && ch_rd))
      else $error("access reached shared and channel sets");

   a_reset_shared: assert property (
      !seen_sel_wr |-> ch_wr == '0 && !ch_rd)
      else $error("channel set reached before selector write");

   c_single_write: cover property (
      acc.wr && route.target == rsts_pkg::RSTS_TO_SINGLE);

   c_bcast_write: cover property (
      acc.wr && route.target == rsts_pkg::RSTS_TO_BCAST);

   c_bcast_read: cover property (
      acc.rd && route.target == rsts_pkg::RSTS_TO_BCAST
      && selector[`RSTS_IDX_MSB:`RSTS_IDX_LSB] == 2'h3);

   c_back_to_shared: cover property (
      selector[`RSTS_CHEN_BIT] ##1 !selector[`RSTS_CHEN_BIT]
      ##[1:8] shr.rd);

   c_single_read: cover property (
      acc.rd && route.target == rsts_pkg::RSTS_TO_SINGLE);

endmodule

// ---- verilog/rsts_regs.svh ----
`ifndef RSTS_REGS_SVH
`define RSTS_REGS_SVH

// selector register location and reset value
`define RSTS_SEL_ADDR    8'hFF
`define RSTS_SEL_RESET   8'h00

// selector field positions
`define RSTS_BCAST_BIT   3
`define RSTS_CHEN_BIT    2
`define RSTS_IDX_MSB     1
`define RSTS_IDX_LSB     0

// value returned by a read of the selector address
`define RSTS_SEL_READ    8'h00

// reset value of every channel register bit
`define RSTS_CH_RESET    8'h00

`endif

// ---- verilog/rsts_pkg.sv ----
package rsts_pkg;

   // one register access as presented by the bus engine
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rsts_access_type;

   // where an access is steered
   typedef enum logic [1:0] {
      RSTS_TO_SHARED,
      RSTS_TO_SINGLE,
      RSTS_TO_BCAST,
      RSTS_TO_SELECTOR
   } rsts_target_type;

   typedef struct packed {
      rsts_target_type target;
      logic [1:0]      channel;
   } rsts_route_type;

endpackage

// ---- verilog/rsts_decode.sv ----
`timescale 1ns/1ps
`include "rsts_regs.svh"

module rsts_decode (
   input  wire logic [7:0]              selector,
   input  wire logic [7:0]              addr,
   output rsts_pkg::rsts_route_type     route
);

   always_comb begin
      route.channel = selector[`RSTS_IDX_MSB:`RSTS_IDX_LSB];
      if (addr == `RSTS_SEL_ADDR) begin
         // selector address never decodes into a channel set
         route.target = rsts_pkg::RSTS_TO_SELECTOR;
      end else if (!selector[`RSTS_CHEN_BIT]) begin
         // broadcast bit alone means nothing
         route.target = rsts_pkg::RSTS_TO_SHARED;
      end else if (selector[`RSTS_BCAST_BIT]) begin
         route.target = rsts_pkg::RSTS_TO_BCAST;
      end else begin
         route.target = rsts_pkg::RSTS_TO_SINGLE;
      end
   end

endmodule

// ---- verilog/rsts_regset.sv ----
`timescale 1ns/1ps
`include "rsts_regs.svh"

module rsts_regset #(
   parameter int                 DEPTH = 255,
   parameter logic [DEPTH*8-1:0] WMASK = {DEPTH{8'hFF}}
) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               wr,
   input  wire logic [7:0]         addr,
   input  wire logic [7:0]         wdata,
   output logic      [7:0]         rdata,
   output logic      [DEPTH*8-1:0] regs
);

   logic [7:0] mem [DEPTH];
   // index only as wide as the set needs
   localparam int AW = $clog2(DEPTH);

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic [7:0] next_q;
      logic [7:0] mask;
      assign mask = WMASK[i*8 +: 8];
      always_comb begin
         next_q = mem[i];
         if (wr && addr == 8'(i)) begin
            // read-only bits keep their value
            next_q = (mem[i] & ~mask) | (wdata & mask);
         end
      end
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            mem[i] <= `RSTS_CH_RESET;
         end else begin
            mem[i] <= next_q;
         end
      end
      assign regs[i*8 +: 8] = mem[i];
   end

   always_comb begin
      if (32'(addr) < DEPTH) begin
         rdata = mem[addr[AW-1:0]];
      end else begin
         rdata = 8'h00;
      end
   end

endmodule

// ---- sim/rsts_shared_model.sv ----
`timescale 1ns/1ps
// shared register set on the far side of the steering block
module rsts_shared_model (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire rsts_pkg::rsts_access_type shr,
   output logic      [7:0]                rdata
);
   logic [7:0] mem [256];
   // not read: inverse shows, so a stray sample is caught
   assign rdata = shr.rd ? mem[shr.addr] : ~mem[shr.addr];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
      end else if (shr.wr) begin
         mem[shr.addr] <= shr.wdata;
      end
   end
endmodule

// ---- sim/register_set_target_select_test.sv ----
`timescale 1ns/1ps
module register_set_target_select_test;
   localparam int D = 16;
   // entry 2 has read-only upper nibble
   localparam logic [D*8-1:0] M = {{13{8'hFF}}, 8'h0F, {2{8'hFF}}};
   logic                      clock = 1'b0;
   logic                      rst_n = 1'b0;
   rsts_pkg::rsts_access_type acc = '0;
   rsts_pkg::rsts_access_type shr;
   logic [7:0]                rd_data;
   logic [7:0]                shr_rdata;
   logic [7:0]                selector;
   logic                      rd_valid;
   logic [4*D*8-1:0]          ch_regs;
   logic [7:0]                sel = 8'h00;
   logic [7:0]                sh [256] = '{default: 8'h00};
   logic [7:0]                ch [4][D] = '{default: 8'h00};
   logic [7:0]                expq [$];
   logic [7:0]                vals [12] = '{8'h04, 8'h0C, 8'h0D, 8'h0E,
      8'h0F, 8'h05, 8'h06, 8'h07, 8'h08, 8'h01, 8'h00, 8'h0F};
   logic [31:0]               seed = 32'h5FEDF4D7;
   logic [31:0]               r;
   logic [7:0]                a;
   int                        fails = 0;
   int                        samples_checked = 0;

   rsts_steer #(.NUM_CH(4), .CH_DEPTH(D), .CH_WMASK(M)) i_rsts_steer (
      .clock(clock), .rst_n(rst_n), .acc(acc), .rd_data(rd_data),
      .rd_valid(rd_valid), .shr(shr), .shr_rdata(shr_rdata),
      .selector(selector), .ch_regs(ch_regs));
   rsts_shared_model i_rsts_shared_model (
      .clock(clock), .rst_n(rst_n), .shr(shr), .rdata(shr_rdata));

   initial forever #4 clock = ~clock;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // one access per cycle, back to back; shadow kept alongside
   task automatic put(input logic w, input logic [7:0] ad,
                      input logic [7:0] d);
      @(negedge clock);
      acc = '{wr: w, rd: !w, addr: ad, wdata: d};
      if (w && ad == 8'hFF) begin
         sel = d;
      end else if (w && !sel[2]) begin
         sh[ad] = d;
      end else if (w) begin
         for (int c = 0; c < 4; c++) begin
            if ((sel[3] || c == sel[1:0]) && ad < D) begin
               ch[c][ad] = (ch[c][ad] & ~M[ad*8+:8]) | (d & M[ad*8+:8]);
            end
         end
      end else begin
         expq.push_back(ad == 8'hFF ? 8'h00 : !sel[2] ? sh[ad] :
                        ad < D ? ch[sel[1:0]][ad] : 8'h00);
      end
   endtask

   task automatic idle();
      @(negedge clock);
      acc = '0;
   endtask

   always @(negedge clock) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) chk(8'(rd_valid), 8'h00);
         else chk(rd_data, expq.pop_front());
      end
   end

   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      chk(selector, 8'h00);
      foreach (vals[i]) begin
         put(1'b1, 8'hFF, vals[i]);
         put(1'b1, 8'h00, vals[i] ^ 8'h3C);
         put(1'b0, 8'h00, 8'h00);
         put(1'b1, 8'h02, 8'hFF);
         put(1'b0, 8'h02, 8'h00);
         put(1'b0, 8'hFF, 8'h00);
         put(1'b0, 8'h1F, 8'h00);
         idle();
         chk(selector, vals[i]);
      end
      repeat (400) begin
         r = xs();
         a = r[20] ? r[31:24] : {3'h0, r[12:8]};
         if (r[1:0] == 2'h0) put(1'b1, 8'hFF, vals[r[7:4] % 12]);
         else if (r[1:0] == 2'h1) put(1'b1, a == 8'hFF ? 8'hFE : a, r[15:8]);
         else put(1'b0, a, 8'h00);
      end
      idle();
      for (int k = 0; k < 10 && expq.size() > 0; k++) @(negedge clock);
      chk(8'(expq.size()), 8'h00);
      for (int c = 0; c < 4; c++) begin
         for (int j = 0; j < D; j++) begin
            chk(ch_regs[(c*D+j)*8+:8], ch[c][j]);
         end
      end
      // mid-run reset: selector and sets must start over
      @(negedge clock);
      rst_n = 1'b0;
      sel = 8'h00;
      sh = '{default: 8'h00};
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      chk(selector, 8'h00);
      chk(ch_regs[7:0], 8'h00);
      put(1'b0, 8'h00, 8'h00);
      idle();
      idle();
      chk(8'(expq.size()), 8'h00);
      report_and_stop();
   end
endmodule
